/* pkg/sbml_defs.svh */
/*
  Offsets, field positions and reset values for the sequencer
  branch / move / load-store decoder.
  Assumes inclusion by bare name from design files.
*/
`ifndef SBML_DEFS_SVH
`define SBML_DEFS_SVH

// ----------------------------------------
// APB register offsets (byte addresses)
// ----------------------------------------
`define SBML_OFF_CTRL      12'h000
`define SBML_OFF_STATUS    12'h004
`define SBML_OFF_DMA_MODE_REG     12'h008
`define SBML_OFF_DMA_CONTROL_REG     12'h00C
`define SBML_OFF_INSTR0    12'h010
`define SBML_OFF_INSTR1    12'h014
`define SBML_OFF_DSA       12'h018
`define SBML_OFF_ALT       12'h01C
`define SBML_OFF_FBC       12'h020
`define SBML_OFF_IP        12'h024
`define SBML_OFF_BCNT      12'h028
`define SBML_OFF_SCSI      12'h02C

// ----------------------------------------
// Field positions, pointer step and type codes
// ----------------------------------------
`define SBML_TC_CMP_DATA   18
`define SBML_TC_CMP_PHASE  17
`define SBML_TC_WAIT_VALID 16
`define SBML_TC_JMP_TRUE   19
`define SBML_MM_NOFLUSH    24
`define SBML_LS_NOFLUSH    25
`define SBML_LS_LOAD       24
`define SBML_LS_DSAREL     28
`define SBML_DMA_MODE_REG_SRC_IO  5
`define SBML_DMA_MODE_REG_DST_IO  4
`define SBML_DMA_CONTROL_REG_PFEN    0
`define SBML_IP_STEP       32'h0000_0004
`define SBML_LS_TYPE       3'h7
`define SBML_MM_TYPE       3'h6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SBML_RST_WORD      32'h0000_0000
`define SBML_RST_BYTE      8'h00

`endif

/* pkg/sbml_pkg.sv */
/*
  Types for the sequencer branch / move / load-store decoder.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sbml_pkg;
  typedef enum logic [2:0] {
    SBML_IDLE,
    SBML_WAIT_PH,
    SBML_MOVE_RD,
    SBML_MOVE_WR,
    SBML_LS_XFER,
    SBML_DONE
  } sbml_state_t;

  typedef enum logic [1:0] {
    SBML_CMD_MEM_RD,
    SBML_CMD_MEM_WR,
    SBML_CMD_IO_RD,
    SBML_CMD_IO_WR
  } sbml_cmd_t;
endpackage

/* core/sbml_decoder.sv */
/*
  Decoder and executor for transfer-control conditions, memory-to-memory
  moves and load/store instructions, with an APB register slave.
  Assumes a host bus master that accepts one word request at a time and
  answers with bm_done, and SCSI phase/attention pins from outside pclk.
*/
`timescale 1ns/1ps
`include "sbml_defs.svh"

// What this block does
// - Compare captured first byte when data flag set
// - Initiator: compare latched phase with phase field
// - Target: phase flag tests attention line
// - Wait flag defers compare until new phase
// - Set mask bits exclude captured byte bits
// - Taken branch: pointer becomes address plus four
// - Move bursts read then write until count zero
// - Move count is low 24 bits
// - Mode bits 5,4 select I/O space
// - Move addresses differing in bits 1-0 raise illegal instruction
// - Nonzero reserved bits 29-25 illegal
// - No-flush bit keeps prefetch when enabled
// - Own-window move uses low seven address bits
// - Base register restored after move
// - Captured byte rejects host and move writes
// - Top bits 111 decode load/store; bit 24
// - Bit 28 selects base plus signed offset
// - Load/store onto self raises illegal instruction
// - Bits 22-16 register, 2-0 byte count
// - Store no-flush bit 25 suppresses flush
// - I/O space load/store uses I/O commands
// - Both compares: true both, false both
module sbml_decoder #(
  parameter logic [31:0] SELF_BASE = 32'h0000_0000,
  parameter int          SELF_BITS = 7
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [2:0]  scsi_phase_pins,
  input  wire logic        scsi_request_line,
  input  wire logic        scsi_attention_line,
  input  wire logic        target_mode,
  output logic             bm_req,
  output logic [1:0]       bm_cmd,
  output logic [31:0]      bm_addr,
  output logic [31:0]      bm_wdata,
  output logic [2:0]       bm_bytes,
  input  wire logic        bm_done,
  input  wire logic [31:0] bm_rdata,
  output logic [6:0]       reg_sel,
  output logic             reg_wr,
  output logic [31:0]      reg_wdata,
  input  wire logic [31:0] reg_rdata,
  output logic             prefetch_flush,
  output logic             branch_taken,
  output logic             exec_done,
  output logic             illegal_instr
);

  // Register select is cut at bit 7
  if (SELF_BITS != 7) begin : g_self_bits_check
    $error("SELF_BITS must be 7");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Mode pin too, though software keeps it static
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic       req_d_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
      req_d_ff <= 1'b0;
    end else begin
      sync1_ff <= {target_mode, scsi_attention_line, scsi_request_line, scsi_phase_pins};
      sync2_ff <= sync1_ff;
      req_d_ff <= sync2_ff[3];
    end
  end
  wire [2:0] phase_s = sync2_ff[2:0];
  wire       req_s   = sync2_ff[3];
  wire       atn_s   = sync2_ff[4];
  wire       tgt_s   = sync2_ff[5];
  wire       req_rise = req_s & ~req_d_ff;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] dma_mode_reg_ff;
  logic [31:0] dma_control_reg_ff;
  logic [31:0] ins0_ff;
  logic [31:0] ins1_ff;
  logic [31:0] dsa_ff;
  logic [31:0] alt_ff;
  logic [31:0] ip_ff;
  logic [31:0] dsa_save_ff;
  logic [31:0] src_ff;
  logic [31:0] dst_ff;
  logic [31:0] data_ff;
  logic [23:0] cnt_ff;
  logic [7:0]  fbc_ff;
  logic [2:0]  phase_lat_ff;
  logic        phase_new_ff;
  logic        illegal_ff;
  logic        done_ff;
  logic        taken_ff;
  logic        busy_ff;
  sbml_pkg::sbml_state_t state_ff;

  wire apb_wr = psel & penable & pwrite;
  wire [31:0] nxt_ip_branch = ins1_ff + `SBML_IP_STEP;

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  wire [2:0]  itype     = ins0_ff[31:29];
  wire        is_ls     = (itype == `SBML_LS_TYPE);
  wire        is_load   = ins0_ff[`SBML_LS_LOAD];
  wire        is_mm     = (itype == `SBML_MM_TYPE);
  wire        is_tc     = (ins0_ff[31:30] == 2'b10);
  wire [23:0] mm_count  = ins0_ff[23:0];
  wire        mm_resv   = |ins0_ff[29:25];
  wire [6:0]  ls_reg    = ins0_ff[22:16];
  wire [2:0]  ls_bytes  = ins0_ff[2:0];
  wire [31:0] ls_off    = {{8{ins1_ff[23]}}, ins1_ff[23:0]};
  wire [31:0] ls_addr   = ins0_ff[`SBML_LS_DSAREL] ? dsa_ff + ls_off : ins1_ff;
  wire        src_io    = dma_mode_reg_ff[`SBML_DMA_MODE_REG_SRC_IO];
  wire        dst_io    = dma_mode_reg_ff[`SBML_DMA_MODE_REG_DST_IO];
  wire        pf_en     = dma_control_reg_ff[`SBML_DMA_CONTROL_REG_PFEN];
  // Own window: upper bits match SELF_BASE
  wire        in_self_s = (src_ff[31:SELF_BITS] == SELF_BASE[31:SELF_BITS]);
  wire        in_self_d = (dst_ff[31:SELF_BITS] == SELF_BASE[31:SELF_BITS]);
  wire        ls_self   = (ls_addr[31:SELF_BITS] == SELF_BASE[31:SELF_BITS]);
  wire        mm_misal  = (dsa_ff[1:0] != alt_ff[1:0]);

  // ----------------------------------------
  // Condition evaluation
  // ----------------------------------------
  wire [7:0] dmask     = ins0_ff[15:8];
  wire       data_ok   = ((fbc_ff ^ ins0_ff[7:0]) & ~dmask) == 8'h00;
  wire       phase_ok  = tgt_s ? atn_s
                                     : (phase_lat_ff == ins0_ff[26:24]);
  wire       use_d     = ins0_ff[`SBML_TC_CMP_DATA];
  wire       use_p     = ins0_ff[`SBML_TC_CMP_PHASE];
  wire       all_true  = (!use_d | data_ok) & (!use_p | phase_ok);
  wire       all_false = (!use_d | !data_ok) & (!use_p | !phase_ok);
  wire       jmp_true  = ins0_ff[`SBML_TC_JMP_TRUE];
  wire       cond_take = jmp_true ? all_true : all_false;
  wire       wait_ph   = ins0_ff[`SBML_TC_WAIT_VALID] & !phase_new_ff;

  // ----------------------------------------
  // Control sequencer
  // ----------------------------------------
  sbml_pkg::sbml_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sbml_pkg::SBML_IDLE: begin
        if (busy_ff) begin
          if (is_tc) begin
            nxt_state = wait_ph ? sbml_pkg::SBML_WAIT_PH : sbml_pkg::SBML_DONE;
          end else if (is_ls) begin
            nxt_state = ls_self ? sbml_pkg::SBML_DONE : sbml_pkg::SBML_LS_XFER;
          end else if (is_mm) begin
            if (mm_resv || mm_misal || mm_count == 24'h000000) begin
              nxt_state = sbml_pkg::SBML_DONE;
            end else begin
              nxt_state = sbml_pkg::SBML_MOVE_RD;
            end
          end else begin
            nxt_state = sbml_pkg::SBML_DONE;
          end
        end
      end
      sbml_pkg::SBML_WAIT_PH: begin
        if (phase_new_ff) begin
          nxt_state = sbml_pkg::SBML_DONE;
        end
      end
      sbml_pkg::SBML_MOVE_RD: begin
        if (in_self_s || bm_done) begin
          nxt_state = sbml_pkg::SBML_MOVE_WR;
        end
      end
      sbml_pkg::SBML_MOVE_WR: begin
        if (in_self_d || bm_done) begin
          nxt_state = (cnt_ff <= 24'h000004) ? sbml_pkg::SBML_DONE
                                             : sbml_pkg::SBML_MOVE_RD;
        end
      end
      sbml_pkg::SBML_LS_XFER: begin
        if (bm_done) begin
          nxt_state = sbml_pkg::SBML_DONE;
        end
      end
      sbml_pkg::SBML_DONE: nxt_state = sbml_pkg::SBML_IDLE;
      default:             nxt_state = sbml_pkg::SBML_IDLE;
    endcase
  end

  wire st_idle = (state_ff == sbml_pkg::SBML_IDLE);
  wire st_rd   = (state_ff == sbml_pkg::SBML_MOVE_RD);
  wire st_wr   = (state_ff == sbml_pkg::SBML_MOVE_WR);
  wire st_ls   = (state_ff == sbml_pkg::SBML_LS_XFER);
  wire st_done = (state_ff == sbml_pkg::SBML_DONE);
  wire start   = st_idle & busy_ff;
  wire mm_bad  = is_mm & (mm_resv | mm_misal);
  // Illegal: skipped, no host cycle
  wire go_ill  = start & ((is_mm & mm_bad) | (is_ls & ls_self));
  // Last beat may be short
  wire [2:0] chunk = (cnt_ff < 24'h000004) ? cnt_ff[2:0] : 3'h4;
  wire rd_step = st_rd & (in_self_s | bm_done);
  wire wr_step = st_wr & (in_self_d | bm_done);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff     <= sbml_pkg::SBML_IDLE;
      busy_ff      <= 1'b0;
      cnt_ff       <= 24'h000000;
      src_ff       <= `SBML_RST_WORD;
      dst_ff       <= `SBML_RST_WORD;
      data_ff      <= `SBML_RST_WORD;
      dsa_save_ff  <= `SBML_RST_WORD;
      ip_ff        <= `SBML_RST_WORD;
      illegal_ff   <= 1'b0;
      done_ff      <= 1'b0;
      taken_ff     <= 1'b0;
      phase_lat_ff <= 3'h0;
      phase_new_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      done_ff  <= st_done;
      if (req_rise) begin
        phase_lat_ff <= phase_s;
      end
      // A new phase arriving in the consuming cycle stays pending
      if (req_rise) begin
        phase_new_ff <= 1'b1;
      end else if (st_done && is_tc) begin
        phase_new_ff <= 1'b0;
      end
      if (apb_wr && paddr == `SBML_OFF_CTRL && pwdata[0]) begin
        busy_ff <= 1'b1;
      end else if (st_done) begin
        busy_ff <= 1'b0;
      end
      if (go_ill) begin
        illegal_ff <= 1'b1;
      end else if (apb_wr && paddr == `SBML_OFF_STATUS && pwdata[1]) begin
        illegal_ff <= 1'b0;
      end
      if (start && is_mm && !mm_bad) begin
        cnt_ff      <= mm_count;
        src_ff      <= alt_ff;
        dst_ff      <= dsa_ff;
        dsa_save_ff <= dsa_ff;
      end
      if (rd_step) begin
        data_ff <= in_self_s ? reg_rdata : bm_rdata;
      end
      if (wr_step) begin
        cnt_ff <= cnt_ff - {21'h000000, chunk};
        src_ff <= src_ff + `SBML_IP_STEP;
        dst_ff <= dst_ff + `SBML_IP_STEP;
      end
      // Pointer moves only on a taken branch
      if (start && is_tc) begin
        taken_ff <= 1'b0;
      end else if (st_done && is_tc && cond_take) begin
        taken_ff <= 1'b1;
        ip_ff    <= nxt_ip_branch;
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_mode_reg_ff <= `SBML_RST_WORD;
      dma_control_reg_ff <= `SBML_RST_WORD;
      ins0_ff  <= `SBML_RST_WORD;
      ins1_ff  <= `SBML_RST_WORD;
      dsa_ff   <= `SBML_RST_WORD;
      alt_ff   <= `SBML_RST_WORD;
      fbc_ff   <= `SBML_RST_BYTE;
    end else begin
      if (apb_wr && paddr == `SBML_OFF_DMA_MODE_REG)  dma_mode_reg_ff <= pwdata;
      if (apb_wr && paddr == `SBML_OFF_DMA_CONTROL_REG)  dma_control_reg_ff <= pwdata;
      if (apb_wr && paddr == `SBML_OFF_INSTR0 && !busy_ff) ins0_ff <= pwdata;
      if (apb_wr && paddr == `SBML_OFF_INSTR1 && !busy_ff) ins1_ff <= pwdata;
      if (apb_wr && paddr == `SBML_OFF_ALT && !busy_ff)    alt_ff <= pwdata;
      // A refused move took no snapshot to restore
      if (st_done && is_mm && !mm_bad) begin
        dsa_ff <= dsa_save_ff;
      end else if (apb_wr && paddr == `SBML_OFF_DSA && !busy_ff) begin
        dsa_ff <= pwdata;
      end
      // Only a sequencer load into register index 0x08 reaches it
      if (st_ls && bm_done && is_load && ls_reg == 7'h08) begin
        fbc_ff <= bm_rdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  wire rd_mem  = st_rd & !in_self_s;
  wire wr_mem  = st_wr & !in_self_d;
  wire ls_mem  = st_ls;
  assign bm_req   = rd_mem | wr_mem | ls_mem;
  assign bm_cmd   = st_rd ? (src_io ? sbml_pkg::SBML_CMD_IO_RD : sbml_pkg::SBML_CMD_MEM_RD)
                  : st_wr ? (dst_io ? sbml_pkg::SBML_CMD_IO_WR : sbml_pkg::SBML_CMD_MEM_WR)
                  : is_load ? (src_io ? sbml_pkg::SBML_CMD_IO_RD : sbml_pkg::SBML_CMD_MEM_RD)
                  : (dst_io ? sbml_pkg::SBML_CMD_IO_WR : sbml_pkg::SBML_CMD_MEM_WR);
  assign bm_addr  = st_rd ? src_ff : st_wr ? dst_ff : ls_addr;
  assign bm_wdata = st_ls ? reg_rdata : data_ff;
  assign bm_bytes = st_ls ? ls_bytes : chunk;
  assign reg_sel  = st_rd ? src_ff[6:0] : st_wr ? dst_ff[6:0] : ls_reg;
  assign reg_wr   = (st_wr & in_self_d) | (st_ls & is_load & bm_done & ls_reg != 7'h08);
  assign reg_wdata = st_ls ? bm_rdata : data_ff;
  // A skipped store leaves prefetch alone
  assign prefetch_flush = st_done & pf_en &
                          ((is_mm & !mm_bad & !ins0_ff[`SBML_MM_NOFLUSH]) |
                           (is_ls & !is_load & !ls_self & !ins0_ff[`SBML_LS_NOFLUSH]));
  assign branch_taken  = taken_ff;
  assign exec_done     = done_ff;
  assign illegal_instr = illegal_ff;

  // Unmapped offsets read as zero
  wire [31:0] status = {27'h0000000, phase_new_ff, taken_ff, busy_ff, illegal_ff, 1'b0};
  logic [31:0] rd_mux;
  always_comb begin
    case (paddr)
      `SBML_OFF_CTRL:   rd_mux = {31'h00000000, busy_ff};
      `SBML_OFF_STATUS: rd_mux = status;
      `SBML_OFF_DMA_MODE_REG:  rd_mux = dma_mode_reg_ff;
      `SBML_OFF_DMA_CONTROL_REG:  rd_mux = dma_control_reg_ff;
      `SBML_OFF_INSTR0: rd_mux = ins0_ff;
      `SBML_OFF_INSTR1: rd_mux = ins1_ff;
      `SBML_OFF_DSA:    rd_mux = dsa_ff;
      `SBML_OFF_ALT:    rd_mux = alt_ff;
      `SBML_OFF_FBC:    rd_mux = {24'h000000, fbc_ff};
      `SBML_OFF_IP:     rd_mux = ip_ff;
      `SBML_OFF_BCNT:   rd_mux = {8'h00, cnt_ff};
      `SBML_OFF_SCSI:   rd_mux = {27'h0000000, atn_s, phase_lat_ff, tgt_s};
      default:          rd_mux = `SBML_RST_WORD;
    endcase
  end
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `SBML_OFF_SCSI);
  // No wait states: every register is a flop
  assign pready  = 1'b1;
  assign pslverr = psel & penable & !mapped;
  assign prdata  = (psel & penable & !pwrite) ? rd_mux : `SBML_RST_WORD;

endmodule

/* verification/sbml_decoder_monitor.sv */
/*
  Port checker for the branch / move / load-store decoder.
  Assumes it is bound to sbml_decoder and shares its clock and reset.
*/
`timescale 1ns/1ps
module sbml_decoder_monitor #(
  parameter logic [31:0] SELF_BASE = 32'h0000_0000,
  parameter int          SELF_BITS = 7
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        bm_req,
  input wire logic [1:0]  bm_cmd,
  input wire logic [31:0] bm_addr,
  input wire logic [2:0]  bm_bytes,
  input wire logic        bm_done,
  input wire logic        prefetch_flush,
  input wire logic        exec_done,
  input wire logic        illegal_instr
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire clr = acc && pwrite && paddr == 12'h004 && pwdata[1];

  apb_ready_a: assert property (acc |-> pready)
    else $error("pready low in access phase");
  read_quiet_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside a read");
  unmapped_err_a: assert property (acc && (paddr > 12'h02C || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("no error on unmapped address");
  mapped_ok_a: assert property (acc && paddr <= 12'h02C && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  req_hold_a: assert property (bm_req && !bm_done |=> bm_req && $stable(bm_addr) && $stable(bm_cmd))
    else $error("host request changed before done");
  self_window_a: assert property (bm_req |-> bm_addr[31:SELF_BITS] != SELF_BASE[31:SELF_BITS])
    else $error("host cycle aimed at own window");
  byte_count_a: assert property (bm_req |-> bm_bytes inside {[3'h1:3'h4]})
    else $error("host byte count out of range");
  done_pulse_a: assert property (exec_done |=> !exec_done)
    else $error("exec_done longer than one cycle");
  flush_done_a: assert property (prefetch_flush |=> exec_done)
    else $error("flush not followed by completion");
  illegal_hold_a: assert property (illegal_instr && !clr |=> illegal_instr)
    else $error("illegal flag dropped without clear");
endmodule

bind sbml_decoder sbml_decoder_monitor #(.SELF_BASE(SELF_BASE), .SELF_BITS(SELF_BITS))
  i_sbml_decoder_monitor (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .bm_req, .bm_cmd, .bm_addr, .bm_bytes, .bm_done,
  .prefetch_flush, .exec_done, .illegal_instr);

/* verification/sbml_host_model.sv */
/*
  Host bus partner: 64-word memory shared by memory and I/O space.
  Assumes one request at a time, held until bm_done.
*/
`timescale 1ns/1ps
module sbml_host_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic        bm_req,
  input  wire logic [1:0]  bm_cmd,
  input  wire logic [31:0] bm_addr,
  input  wire logic [31:0] bm_wdata,
  input  wire logic [2:0]  bm_bytes,
  output logic             bm_done,
  output logic [31:0]      bm_rdata
);
  // ----------------------------------------
  // Memory and request log
  // ----------------------------------------
  logic [31:0] mem [64];
  logic [2:0]  wait_ff;
  logic [1:0]  last_cmd;
  logic [31:0] last_addr;
  logic [31:0] last_wdata;
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'h5A5A_5A00 + 32'(i);
    end
  end
  // Read data toggles outside done so a stale sample never looks valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bm_done  <= 1'b0;
      bm_rdata <= 32'h0000_0000;
      wait_ff  <= 3'h0;
    end else begin
      bm_done  <= 1'b0;
      bm_rdata <= ~bm_rdata;
      if (bm_req && !bm_done && wait_ff < (slow ? 3'h5 : 3'h0)) begin
        wait_ff <= wait_ff + 3'h1;
      end else if (bm_req && !bm_done) begin
        wait_ff    <= 3'h0;
        bm_done    <= 1'b1;
        last_cmd   <= bm_cmd;
        last_addr  <= bm_addr;
        last_wdata <= bm_wdata;
        if (!bm_cmd[0]) begin
          bm_rdata <= mem[bm_addr[7:2]];
        end
        for (int b = 0; b < 4; b++) begin
          if (bm_cmd[0] && b >= bm_addr[1:0] && b < bm_addr[1:0] + bm_bytes) begin
            mem[bm_addr[7:2]][8*b +: 8] <= bm_wdata[8*b +: 8];
          end
        end
      end
    end
  end
endmodule

/* verification/sbml_decoder_bench.sv */
/*
  Self-checking bench for the branch / move / load-store decoder.
  Assumes the host model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
`include "sbml_defs.svh"
module sbml_decoder_bench;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, slow, bm_req, bm_done;
  logic        scsi_request_line, scsi_attention_line, target_mode, reg_wr;
  logic        prefetch_flush, branch_taken, exec_done, illegal_instr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, bm_addr, bm_wdata, bm_rdata, reg_wdata, reg_rdata, last_rw;
  logic [2:0]  scsi_phase_pins, bm_bytes;
  logic [1:0]  bm_cmd;
  logic [6:0]  reg_sel, last_sel;
  int          failures, samples_checked, xfers, flushes, dones;

  sbml_decoder i_sbml_decoder (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .scsi_phase_pins, .scsi_request_line, .scsi_attention_line, .target_mode, .bm_req,
    .bm_cmd, .bm_addr, .bm_wdata, .bm_bytes, .bm_done, .bm_rdata, .reg_sel, .reg_wr,
    .reg_wdata, .reg_rdata, .prefetch_flush, .branch_taken, .exec_done, .illegal_instr);
  sbml_host_model i_sbml_host_model (.pclk, .presetn, .slow, .bm_req, .bm_cmd, .bm_addr,
    .bm_wdata, .bm_bytes, .bm_done, .bm_rdata);
  assign reg_rdata = {reg_sel, 25'h0000ACE};
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    if (bm_done === 1'b1) xfers++;
    if (prefetch_flush === 1'b1) flushes++;
    if (exec_done === 1'b1) dones++;
    if (reg_wr === 1'b1) last_sel = reg_sel;
    if (reg_wr === 1'b1) last_rw = reg_wdata;
  end

  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic start(input logic [31:0] i0, input logic [31:0] i1);
    wr(`SBML_OFF_INSTR0, i0);
    wr(`SBML_OFF_INSTR1, i1);
    wr(`SBML_OFF_ALT, i1);
    wr(`SBML_OFF_CTRL, 32'h0000_0001);
  endtask
  task automatic finish;
    int n;
    n = 0;
    while (exec_done !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, exec_done}, 32'h1);
    @(posedge pclk);
  endtask
  task automatic run(input logic [31:0] i0, input logic [31:0] i1);
    start(i0, i1);
    finish;
  endtask
  // Phase lines settle before request rises, past the two-stage sync
  task automatic phase(input logic [2:0] p);
    scsi_phase_pins <= p;
    repeat (4) @(posedge pclk);
    scsi_request_line <= 1'b1;
    repeat (4) @(posedge pclk);
    scsi_request_line <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_apb;
    logic [31:0] q;
    logic        e;
    apb(1'b0, 12'h030, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    wr(`SBML_OFF_FBC, 32'h0000_00FF);
    rd(`SBML_OFF_FBC, q);
    chk(q, 32'h0);
    $display("apb test done");
  endtask
  task automatic t_ls;
    logic [31:0] q;
    int          f;
    run(32'hE108_0001, 32'h0000_0080);
    rd(`SBML_OFF_FBC, q);
    chk(q, 32'h0000_0020);
    wr(`SBML_OFF_DSA, 32'h0000_0100);
    wr(`SBML_OFF_DMA_MODE_REG, 32'h0000_0020);
    run(32'hF110_0004, 32'h00FF_FFC0);
    chk(i_sbml_host_model.last_addr, 32'h0000_00C0);
    chk({30'h0, i_sbml_host_model.last_cmd}, {30'h0, sbml_pkg::SBML_CMD_IO_RD});
    chk({25'h0, last_sel}, 32'h10);
    chk(last_rw, 32'h5A5A_5A30);
    wr(`SBML_OFF_DMA_MODE_REG, 32'h0000_0010);
    wr(`SBML_OFF_DMA_CONTROL_REG, 32'h0000_0001);
    f = flushes;
    run(32'hE024_0004, 32'h0000_0084);
    chk(i_sbml_host_model.last_wdata, {7'h24, 25'h0000ACE});
    chk({30'h0, i_sbml_host_model.last_cmd}, {30'h0, sbml_pkg::SBML_CMD_IO_WR});
    run(32'hE224_0004, 32'h0000_0084);
    chk(32'(flushes - f), 32'h1);
    wr(`SBML_OFF_DMA_MODE_REG, 32'h0);
    $display("load store test done");
  endtask
  task automatic t_illegal;
    logic [31:0] q;
    int          x;
    logic [31:0] data_structure_base_reg [3] = '{32'h0000_00A1, 32'h0000_00A0, 32'h0000_00A0};
    logic [31:0] ins [3] = '{32'hC000_0004, 32'hC200_0004, 32'hE024_0004};
    logic [31:0] adr [3] = '{32'h0000_0090, 32'h0000_0090, 32'h0000_0040};
    for (int k = 0; k < 3; k++) begin
      wr(`SBML_OFF_DSA, data_structure_base_reg[k]);
      x = xfers;
      run(ins[k], adr[k]);
      chk(32'(xfers - x), 32'h0);
      chk({31'h0, illegal_instr}, 32'h1);
      wr(`SBML_OFF_STATUS, 32'h0000_0002);
      rd(`SBML_OFF_DSA, q);
      chk(q, data_structure_base_reg[k]);
    end
    rd(`SBML_OFF_STATUS, q);
    chk(q & 32'h2, 32'h0);
    $display("illegal test done");
  endtask
  task automatic t_move;
    logic [31:0] q;
    int          x;
    int          f;
    wr(`SBML_OFF_DMA_CONTROL_REG, 32'h0000_0001);
    wr(`SBML_OFF_DSA, 32'h0000_00A0);
    slow <= 1'b1;
    f = flushes;
    x = xfers;
    run(32'hC000_0008, 32'h0000_0090);
    chk(i_sbml_host_model.mem[40], 32'h5A5A_5A24);
    chk(i_sbml_host_model.mem[41], 32'h5A5A_5A25);
    chk(32'(xfers - x), 32'h4);
    rd(`SBML_OFF_DSA, q);
    chk(q, 32'h0000_00A0);
    run(32'hC100_0004, 32'h0000_0090);
    wr(`SBML_OFF_DMA_CONTROL_REG, 32'h0);
    run(32'hC000_0004, 32'h0000_0044);
    chk(i_sbml_host_model.mem[40], {7'h44, 25'h0000ACE});
    chk(32'(flushes - f), 32'h1);
    slow <= 1'b0;
    $display("move test done");
  endtask
  task automatic t_branch;
    logic [31:0] q;
    int          d;
    logic [31:0] tc [9] = '{32'h800C_DF3F, 32'h800C_003F, 32'h830A_0000, 32'h810A_0000,
      32'h830E_0020, 32'h830E_0021, 32'h810E_0021, 32'h8106_0021, 32'h8306_0021};
    logic [8:0]  tk = 9'h095;
    phase(3'h3);
    for (int k = 0; k < 9; k++) begin
      run(tc[k], 32'h0000_1000);
      chk({31'h0, branch_taken}, {31'h0, tk[k]});
      if (tk[k]) begin
        rd(`SBML_OFF_IP, q);
        chk(q, 32'h0000_1004);
      end
    end
    target_mode <= 1'b1;
    scsi_attention_line <= 1'b1;
    run(32'h800A_0000, 32'h0000_1000);
    chk({31'h0, branch_taken}, 32'h1);
    scsi_attention_line <= 1'b0;
    run(32'h800A_0000, 32'h0000_1000);
    chk({31'h0, branch_taken}, 32'h0);
    target_mode <= 1'b0;
    phase(3'h3);
    run(32'h830B_0000, 32'h0000_1000);
    start(32'h830B_0000, 32'h0000_1000);
    d = dones;
    repeat (30) @(posedge pclk);
    chk(32'(dones - d), 32'h0);
    phase(3'h3);
    chk(32'(dones - d), 32'h1);
    chk({31'h0, branch_taken}, 32'h1);
    $display("branch test done");
  endtask

  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, slow, target_mode} = 6'h00;
    {scsi_request_line, scsi_attention_line, scsi_phase_pins} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_apb;
    t_ls;
    t_illegal;
    t_move;
    t_branch;
    end_of_test;
  end
  // Whole run needs under a thousand cycles; this leaves wide margin
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    end_of_test;
  end
endmodule
